// File: rtl/clk_net_pkg.sv
package clk_net_pkg;

  // ----------------------------------------
  // Network sizes
  // ----------------------------------------
  localparam int GLOBAL_LINES = 32;
  localparam int REGIONAL_NETS = 8;
  localparam int EDGE_NETS = 1;
  localparam int REG_LINES = 2 * REGIONAL_NETS + 2 * EDGE_NETS;
  localparam int REG_TOP_IDX = 16;
  localparam int REG_BOT_IDX = 17;
  localparam int DYN_MUXES = 8;
  localparam int DYN_PER_SIDE = 2;
  localparam int DYN_INPUTS = 4;
  localparam int PLL_OUTS = 8;
  localparam int LANES = 4;
  localparam int GPIO_P = 12;

  // ----------------------------------------
  // Global line map
  // ----------------------------------------
  localparam int GL_PLL_BASE = 8;
  localparam int GL_LANE_BASE = 16;
  localparam int GL_GPIO_BASE = 20;
  localparam logic [3:0] LANE_CLOCK_CAP = 4'h5;

  // ----------------------------------------
  // Local networks
  // ----------------------------------------
  localparam int REGION_ROWS = 80;
  localparam int LOCAL_ROWS = 40;
  localparam int LOCAL_KINDS = 3;
  localparam int LOCAL_FEEDS = 16;
  localparam int FAB_FEEDS = 16;
  localparam int REG_CAND_CORE = 4;
  localparam int REG_CAND_EDGE = 8;
  localparam int POOL_FAB_BASE = 32;
  localparam int POOL_REG_BASE = 48;
  localparam logic [5:0] POOL_LIM_CORE = 6'h34;
  localparam logic [5:0] POOL_LIM_EDGE = 6'h38;
  localparam int EDGE_GLOBAL = 14;
  localparam int EDGE_FAB = 2;
  localparam int SIDE_CLKS = 4;
  localparam int SIDE_FAB_MAX = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [1:0] DYN_RESET_SEL = 2'h0;

  typedef struct packed {
    logic [7:0][3:0] dyn;
    logic [7:0] pll;
    logic [3:0] lane;
    logic [11:0] gpio_p;
    logic [31:0] core;
    logic [17:0] reg_src;
    logic [15:0] fabric;
  } src_s;

  typedef enum logic [1:0] {MUX_RUN, MUX_DROP, MUX_ARM} mux_st_e;

  typedef struct packed {
    mux_st_e st;
    logic [1:0] act;
    logic on;
    logic out;
  } mux_s;

  typedef struct packed {
    src_s s1;
    src_s s2;
    logic [31:0] gl_on;
    logic [31:0] gl;
    logic [17:0] rg_on;
    logic [17:0] rg;
    logic [2:0][15:0] loc;
    logic [15:0] edge_f;
    logic [3:0] side;
    logic [39:0] ce;
  } top_s;

endpackage : clk_net_pkg

// File: rtl/dyn_clock_mux.sv
`timescale 1ns/1ns
module dyn_clock_mux (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] clk_in,
  input wire logic [1:0] sel,
  output logic clk_out,
  output logic [1:0] active_sel
);

  clk_net_pkg::mux_s st_reg;
  clk_net_pkg::mux_s st_next;

  // ----------------------------------------
  // Break before make
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg.st)
      clk_net_pkg::MUX_RUN:
        // RULE7: run-time switch
        if (sel != st_reg.act)
        begin
          st_next.st = clk_net_pkg::MUX_DROP;
        end
      clk_net_pkg::MUX_DROP:
        // RULE23: old input off low
        if (!clk_in[st_reg.act])
        begin
          st_next.on = 1'b0;
          st_next.act = sel;
          st_next.st = clk_net_pkg::MUX_ARM;
        end
      clk_net_pkg::MUX_ARM:
        // RULE23: new input on low
        if (!clk_in[st_reg.act])
        begin
          st_next.on = 1'b1;
          st_next.st = clk_net_pkg::MUX_RUN;
        end
      default:
        st_next.st = clk_net_pkg::MUX_RUN;
    endcase
    st_next.out = st_next.on & clk_in[st_next.act];
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      // RULE10: input 0 after reset
      st_reg.st <= clk_net_pkg::MUX_RUN;
      st_reg.act <= clk_net_pkg::DYN_RESET_SEL;
      st_reg.on <= 1'b1;
      st_reg.out <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign clk_out = st_reg.out;
  assign active_sel = st_reg.act;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_mux_default_in0: assert property (@(posedge mclk) // RULE10
    $fell(sys_rst) |-> st_reg.act == 2'h0 && st_reg.on)
    else $error("mux not on input 0 after reset");

  a_mux_break_first: assert property (@(posedge mclk) disable iff (sys_rst) // RULE23
    $changed(st_reg.act) |-> !st_reg.on && !st_reg.out ##1 !st_reg.out)
    else $error("mux changed input while on");

  a_mux_no_runt: assert property (@(posedge mclk) disable iff (sys_rst) // RULE23
    $rose(st_reg.on) |-> !$past(clk_in[st_reg.act]))
    else $error("mux enabled on high input");

  c_mux_switch: cover property (@(posedge mclk) disable iff (sys_rst)
    st_reg.st == clk_net_pkg::MUX_ARM ##[1:20] st_reg.st == clk_net_pkg::MUX_RUN);

endmodule : dyn_clock_mux

// File: rtl/clock_distribution_network.sv
`timescale 1ns/1ns
// Operation
// RULE1: 32 balanced global lines, clock or control
// RULE2: eight regional networks, own region only
// RULE3: top and bottom one regional each
// RULE4: left and right halves driven independently
// RULE5: networks driven only through global buffers
// RULE6: per-network glitch-free run-time enable gate
// RULE7: eight dynamic muxes, switchable in operation
// RULE8: user select bus picks mux input
// RULE9: user keeps both inputs toggling during switch
// RULE10: dynamic muxes start on input 0
// RULE11: user runs input 0 before switching
// RULE12: only positive pin member drives clocks
// RULE13: clock-capable lanes drive global, regional optional
// RULE14: every PLL output reaches global network
// RULE15: regions 80 tall, local slice 40
// RULE16: separate local networks per column, block kind
// RULE17: at most 16 feeds per local network
// RULE18: feeds from 32 global, 16 fabric
// RULE19: regional candidates eight at edges, else four
// RULE20: fabric drives local clocks and cell enables
// RULE21: edge regions 14 global plus 2 fabric
// RULE22: side regions four clocks, two fabric max
// RULE23: mux drops old low, arms new low
module clock_distribution_network (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire clk_net_pkg::src_s src_in,
  input wire logic [7:0][1:0] dyn_sel,
  input wire logic [31:0] global_en,
  input wire logic [17:0] regional_en,
  input wire logic [11:0] gpio_use,
  input wire logic [3:0] lane_regional,
  input wire logic loc_edge,
  input wire logic [2:0][15:0][5:0] loc_sel,
  input wire logic [13:0][4:0] edge_sel,
  input wire logic [3:0][5:0] side_sel,
  input wire logic [39:0] cell_ce_in,
  output logic [31:0] global_clock_line,
  output logic [17:0] regional_line,
  output logic [2:0][15:0] local_feed,
  output logic [15:0] edge_feed,
  output logic [3:0] side_feed,
  output logic [39:0] cell_ce,
  output logic [7:0][1:0] dyn_active
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  clk_net_pkg::top_s st_reg;
  clk_net_pkg::top_s st_next;
  logic [31:0] gsrc;
  logic [17:0] rsrc;
  logic [55:0] pool;
  logic [5:0] lim;
  logic [7:0] dyn_out;

  // Gate only moves while its source is low, so no runt
  function automatic logic gate_upd(input logic on, input logic en,
                                    input logic src);
    gate_upd = src ? on : en;
  endfunction : gate_upd

  // Out-of-range picks give a quiet low line
  function automatic logic pick(input logic [55:0] p, input logic [5:0] s,
                                input logic [5:0] l);
    pick = (s < l) ? p[s] : 1'b0;
  endfunction : pick

  function automatic logic is_fab(input logic [5:0] s);
    is_fab = (s >= 6'(clk_net_pkg::POOL_FAB_BASE)) &&
             (s < 6'(clk_net_pkg::POOL_REG_BASE));
  endfunction : is_fab

  // ----------------------------------------
  // Dynamic muxes
  // ----------------------------------------
  // RULE7: two per side, four sides
  // RULE9: relies on toggling inputs
  // RULE11: relies on input 0 running
  for (genvar m = 0; m < clk_net_pkg::DYN_MUXES; m++)
  begin : g_dyn
    dyn_clock_mux u_mux (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clk_in(st_reg.s2.dyn[m]),
      // RULE8: user select bus
      .sel(dyn_sel[m]),
      .clk_out(dyn_out[m]),
      .active_sel(dyn_active[m])
    );
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    // Pins and foreign clocks pass two flops first
    st_next.s1 = src_in;
    st_next.s2 = st_reg.s1;

    // RULE5: buffer sources core or interface
    for (int i = 0; i < 32; i++)
    begin
      gsrc[i] = st_reg.s2.core[i];
    end
    // RULE7: low lines from dynamic muxes
    gsrc[7:0] = dyn_out;
    // RULE14: every PLL output on global
    gsrc[15:8] = st_reg.s2.pll;
    // RULE13: capable lanes, global by default
    for (int i = 0; i < clk_net_pkg::LANES; i++)
    begin
      if (clk_net_pkg::LANE_CLOCK_CAP[i] && !lane_regional[i])
      begin
        gsrc[clk_net_pkg::GL_LANE_BASE + i] = st_reg.s2.lane[i];
      end
    end
    // RULE12: only P member has a path
    for (int i = 0; i < clk_net_pkg::GPIO_P; i++)
    begin
      if (gpio_use[i])
      begin
        gsrc[clk_net_pkg::GL_GPIO_BASE + i] = st_reg.s2.gpio_p[i];
      end
    end

    // RULE4: each half has its own source
    rsrc = st_reg.s2.reg_src;
    // RULE13: optional regional lane drive
    for (int i = 0; i < clk_net_pkg::LANES; i++)
    begin
      if (clk_net_pkg::LANE_CLOCK_CAP[i] && lane_regional[i])
      begin
        rsrc[2 * i] = st_reg.s2.lane[i];
      end
    end

    // RULE6: glitch-free global gates
    // RULE1: 32 lines, clock or control
    for (int i = 0; i < clk_net_pkg::GLOBAL_LINES; i++)
    begin
      st_next.gl_on[i] = gate_upd(st_reg.gl_on[i], global_en[i], gsrc[i]);
    end
    st_next.gl = gsrc & st_next.gl_on;

    // RULE6: glitch-free regional gates
    // RULE2: nets 0..7 halves, own region
    // RULE3: one each top and bottom
    for (int i = 0; i < clk_net_pkg::REG_LINES; i++)
    begin
      st_next.rg_on[i] = gate_upd(st_reg.rg_on[i], regional_en[i], rsrc[i]);
    end
    st_next.rg = rsrc & st_next.rg_on;

    // RULE18: global then fabric candidates
    pool[31:0] = st_reg.gl;
    pool[47:32] = st_reg.s2.fabric;
    // RULE19: eight regional at edges, four elsewhere
    pool[55:48] = st_reg.rg[7:0];
    lim = loc_edge ? clk_net_pkg::POOL_LIM_EDGE : clk_net_pkg::POOL_LIM_CORE;

    // RULE16: logic, memory, arithmetic separate
    // RULE17: sixteen feeds per network
    for (int k = 0; k < clk_net_pkg::LOCAL_KINDS; k++)
    begin
      for (int j = 0; j < clk_net_pkg::LOCAL_FEEDS; j++)
      begin
        st_next.loc[k][j] = pick(pool, loc_sel[k][j], lim);
      end
    end

    // RULE21: 14 global plus 2 fabric
    for (int j = 0; j < clk_net_pkg::EDGE_GLOBAL; j++)
    begin
      st_next.edge_f[j] = st_reg.gl[edge_sel[j]];
    end
    st_next.edge_f[15:14] = st_reg.s2.fabric[1:0];

    // RULE22: fabric only in first two slots
    for (int j = 0; j < clk_net_pkg::SIDE_CLKS; j++)
    begin
      if (j >= clk_net_pkg::SIDE_FAB_MAX && is_fab(side_sel[j]))
      begin
        st_next.side[j] = 1'b0;
      end
      else
      begin
        st_next.side[j] = pick(pool, side_sel[j], clk_net_pkg::POOL_LIM_CORE);
      end
    end

    // RULE20: per-cell enable straight from fabric
    // RULE15: one enable per row of a 40-row slice
    st_next.ce = cell_ce_in;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign global_clock_line = st_reg.gl;
  assign regional_line = st_reg.rg;
  assign local_feed = st_reg.loc;
  assign edge_feed = st_reg.edge_f;
  assign side_feed = st_reg.side;
  assign cell_ce = st_reg.ce;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_gl_gate_quiet: assert property (@(posedge mclk) disable iff (sys_rst) // RULE6
    $changed(st_reg.gl_on) |->
      (($past(st_reg.gl_on) ^ st_reg.gl_on) & $past(gsrc)) == 32'h0)
    else $error("global gate moved while source high");

  a_rg_gate_quiet: assert property (@(posedge mclk) disable iff (sys_rst) // RULE6
    $changed(st_reg.rg_on) |->
      (($past(st_reg.rg_on) ^ st_reg.rg_on) & $past(rsrc)) == 18'h0)
    else $error("regional gate moved while source high");

  a_gl_off_low: assert property (@(posedge mclk) disable iff (sys_rst) // RULE1
    (st_reg.gl & ~st_reg.gl_on) == 32'h0)
    else $error("disabled global line active");

  a_pll_on_global: assert property (@(posedge mclk) disable iff (sys_rst) // RULE14
    !$past(sys_rst) |->
      st_reg.gl[15:8] == ($past(st_reg.s2.pll) & st_reg.gl_on[15:8]))
    else $error("pll output not on its global line");

  a_gpio_p_only: assert property (@(posedge mclk) disable iff (sys_rst) // RULE12
    !$past(sys_rst) |->
      st_reg.gl[31:20] == ((($past(gpio_use) & $past(st_reg.s2.gpio_p)) |
        (~$past(gpio_use) & $past(st_reg.s2.core[31:20]))) & st_reg.gl_on[31:20]))
    else $error("gpio global line wrong source");

  a_lane_global: assert property (@(posedge mclk) disable iff (sys_rst) // RULE13
    !$past(sys_rst) && !$past(lane_regional[0]) && st_reg.gl_on[16] |->
      st_reg.gl[16] == $past(st_reg.s2.lane[0]))
    else $error("clock lane missing from global");

  a_local_pick: assert property (@(posedge mclk) disable iff (sys_rst) // RULE18
    !$past(sys_rst) |->
      st_reg.loc[0][0] == pick($past(pool), $past(loc_sel[0][0]), $past(lim)))
    else $error("local feed wrong candidate");

  a_core_reg_four: assert property (@(posedge mclk) disable iff (sys_rst) // RULE19
    !loc_edge && loc_sel[1][3] >= 6'h34 |=> !st_reg.loc[1][3])
    else $error("core local took extra regional candidate");

  a_side_fab_cap: assert property (@(posedge mclk) disable iff (sys_rst) // RULE22
    is_fab(side_sel[3]) |=> !st_reg.side[3])
    else $error("side slot 3 took fabric");

  a_edge_fab: assert property (@(posedge mclk) disable iff (sys_rst) // RULE21
    !$past(sys_rst) |-> st_reg.edge_f[15:14] == $past(st_reg.s2.fabric[1:0]))
    else $error("edge fabric feeds wrong");

  a_cell_ce: assert property (@(posedge mclk) disable iff (sys_rst) // RULE20
    !$past(sys_rst) |-> cell_ce == $past(cell_ce_in))
    else $error("cell enable not passed");

  c_gl_enable: cover property (@(posedge mclk) disable iff (sys_rst)
    $rose(st_reg.gl_on[9]) ##[1:10] st_reg.gl[9]);

  c_rg_disable: cover property (@(posedge mclk) disable iff (sys_rst)
    $fell(st_reg.rg_on[16]));

  c_edge_local: cover property (@(posedge mclk) disable iff (sys_rst)
    loc_edge && loc_sel[0][3] >= 6'h34 ##1 st_reg.loc[0][3]);

endmodule : clock_distribution_network

// File: tb/user_core_model.sv
`timescale 1ns/1ns
module user_core_model (
  input wire logic mclk,
  input wire logic run,
  input wire clk_net_pkg::src_s pat,
  output clk_net_pkg::src_s src
);
  // ----------------------------------------
  // Free running source clocks
  // ----------------------------------------
  logic [3:0] cnt = 4'h0;

  always_ff @(negedge mclk)
  begin
    cnt <= cnt + 4'h1;
  end

  // mux inputs toggle
  // Input i runs at mclk over 2^(i+1), so input 0 is always live and every
  // pair of inputs toggles through a switch; static bits follow the bench.
  always_comb
  begin
    src = pat;
    if (run)
    begin
      for (int m = 0; m < 8; m++)
        src.dyn[m] = cnt;
    end
  end
endmodule : user_core_model

// File: tb/test_clock_distribution_network.sv
`timescale 1ns/1ns
module test_clock_distribution_network;
  logic mclk;
  logic sys_rst;
  logic run;
  clk_net_pkg::src_s pat;
  clk_net_pkg::src_s src_in;
  logic [7:0][1:0] dyn_sel;
  logic [31:0] global_en;
  logic [17:0] regional_en;
  logic [11:0] gpio_use;
  logic [3:0] lane_regional;
  logic loc_edge;
  logic [2:0][15:0][5:0] loc_sel;
  logic [13:0][4:0] edge_sel;
  logic [3:0][5:0] side_sel;
  logic [39:0] cell_ce_in;
  logic [31:0] global_clock_line;
  logic [17:0] regional_line;
  logic [2:0][15:0] local_feed;
  logic [15:0] edge_feed;
  logic [3:0] side_feed;
  logic [39:0] cell_ce;
  logic [7:0][1:0] dyn_active;
  int err_total = 0;
  int num_checks = 0;

  // Lines 0..7 carry the dynamic muxes; lines 0 and 3 are judged by their toggle count
  localparam logic [31:0] GL_MASK = 32'hFFFF_FF00;

  user_core_model far_u (.mclk(mclk), .run(run), .pat(pat), .src(src_in));

  clock_distribution_network dut_u (.mclk(mclk), .sys_rst(sys_rst), .src_in(src_in),
    .dyn_sel(dyn_sel), .global_en(global_en), .regional_en(regional_en),
    .gpio_use(gpio_use), .lane_regional(lane_regional), .loc_edge(loc_edge),
    .loc_sel(loc_sel), .edge_sel(edge_sel), .side_sel(side_sel), .cell_ce_in(cell_ce_in),
    .global_clock_line(global_clock_line), .regional_line(regional_line),
    .local_feed(local_feed), .edge_feed(edge_feed), .side_feed(side_feed),
    .cell_ce(cell_ce), .dyn_active(dyn_active));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [31:0] exp_gl();
    logic [31:0] e;
    e = 32'h0;
    e[15:8] = pat.pll;
    e[16] = pat.lane[0];
    e[17] = pat.core[17];
    e[18] = pat.lane[2];
    e[19] = pat.core[19];
    for (int i = 0; i < 12; i++)
      e[20 + i] = gpio_use[i] ? pat.gpio_p[i] : pat.core[20 + i];
    return e;
  endfunction : exp_gl

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_test;
    idle(2);
    chk("reset lines", 64'h0, {global_clock_line, 14'h0, regional_line});
    chk("reset active", 64'h0, {48'h0, dyn_active});
    sys_rst = 1'b0;
    idle(5);
    chk("active after reset", 64'h0, {48'h0, dyn_active});
  endtask : reset_test

  task automatic global_test;
    pat.pll = 8'h96;
    pat.lane = 4'hF;
    pat.gpio_p = 12'h3C5;
    pat.core = 32'h5A5A_C33C;
    pat.reg_src = 18'h2_5A79;
    pat.fabric = 16'hBEEF;
    idle(5);
    chk("global", {32'h0, exp_gl()}, {32'h0, global_clock_line & GL_MASK});
    chk("regional", {46'h0, pat.reg_src}, {46'h0, regional_line});
  endtask : global_test

  task automatic local_test;
    loc_sel[0][0] = 6'h09;
    loc_sel[0][1] = 6'h23;
    loc_sel[0][2] = 6'h30;
    loc_sel[0][3] = 6'h34;
    loc_sel[1][0] = 6'h3F;
    loc_sel[1][3] = 6'h36;
    loc_sel[2][15] = 6'h14;
    edge_sel[0] = 5'h09;
    side_sel = {6'h2F, 6'h30, 6'h0A, 6'h21};
    idle(2);
    chk("local core", {61'h0, pat.reg_src[0], pat.fabric[3], pat.pll[1]},
      {60'h0, local_feed[0][3:0]});
    chk("local kinds", ({32'h0, exp_gl()} >> 20) & 64'h1,
      {61'h0, local_feed[1][0], local_feed[1][3], local_feed[2][15]});
    chk("edge feed", {61'h0, pat.fabric[1:0], pat.pll[1]},
      {61'h0, edge_feed[15:14], edge_feed[0]});
    chk("side feed", {60'h0, 1'b0, pat.reg_src[0], pat.pll[2], pat.fabric[1]},
      {60'h0, side_feed});
    loc_edge = 1'b1;
    idle(2);
    chk("local edge", {62'h0, pat.reg_src[4], pat.reg_src[6]},
      {62'h0, local_feed[0][3], local_feed[1][3]});
    loc_edge = 1'b0;
  endtask : local_test

  task automatic lane_test;
    pat.reg_src = 18'h0;
    lane_regional = 4'h3;
    idle(5);
    chk("lane regional", 64'h1, {61'h0, regional_line[2:0]});
    chk("lane global", 64'h0, {63'h0, global_clock_line[16]});
    lane_regional = 4'h0;
    pat.reg_src = 18'h2_5A79;
    idle(5);
  endtask : lane_test

  task automatic ce_test;
    cell_ce_in = 40'hA5_5A0F_F0C3;
    idle(1);
    chk("cell enable", {24'h0, cell_ce_in}, {24'h0, cell_ce});
    cell_ce_in = 40'h0F_0000_FFFF;
    idle(1);
    chk("cell enable", {24'h0, cell_ce_in}, {24'h0, cell_ce});
  endtask : ce_test

  task automatic dyn_test(input int m, input logic [1:0] s);
    int n;
    int flips;
    logic prev;
    n = 0;
    flips = 0;
    dyn_sel[m] = s;
    while (dyn_active[m] !== s && n < 100)
    begin
      idle(1);
      n++;
    end
    chk("dyn active", {62'h0, s}, {62'h0, dyn_active[m]});
    idle(40);
    // Input s of the model has a half period of 2^s cycles
    prev = global_clock_line[m];
    for (int i = 0; i < 16; i++)
    begin
      idle(1);
      if (global_clock_line[m] !== prev)
        flips++;
      prev = global_clock_line[m];
    end
    chk("dyn toggles", 64'(16 >> s), 64'(flips));
  endtask : dyn_test

  task automatic gate_test;
    global_en[9] = 1'b0;
    regional_en[16] = 1'b0;
    idle(5);
    chk("gate holds high", 64'h1, {63'h0, global_clock_line[9]});
    pat.pll[1] = 1'b0;
    idle(5);
    pat.pll[1] = 1'b1;
    idle(5);
    chk("gate closed", 64'h0, {63'h0, global_clock_line[9]});
    global_en[9] = 1'b1;
    idle(5);
    chk("gate waits low", 64'h0, {63'h0, global_clock_line[9]});
    pat.pll[1] = 1'b0;
    idle(5);
    pat.pll[1] = 1'b1;
    idle(5);
    chk("gate reopens", 64'h1, {63'h0, global_clock_line[9]});
  endtask : gate_test

  initial
  begin
    sys_rst = 1'b1;
    run = 1'b1;
    pat = '0;
    dyn_sel = '0;
    global_en = 32'hFFFF_FFFF;
    regional_en = 18'h3_FFFF;
    gpio_use = 12'hA5C;
    lane_regional = 4'h0;
    loc_edge = 1'b0;
    loc_sel = '0;
    edge_sel = '0;
    side_sel = '0;
    cell_ce_in = 40'h0;
    reset_test();
    global_test();
    local_test();
    lane_test();
    ce_test();
    dyn_test(0, 2'h1);
    dyn_test(3, 2'h3);
    dyn_test(0, 2'h0);
    chk("other muxes", 64'h0, {48'h0, dyn_active & 16'hFF3F});
    gate_test();
    report_and_stop();
  end

  initial
  begin
    repeat (5000) @(posedge mclk);
    err_total++;
    report_and_stop();
  end
endmodule : test_clock_distribution_network
